// file: eip_checker.sv
// Concurrent checks on the link between controller and core.
// Assumes one clock; link signals are wired in as plain inputs.
module eip_checker (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [3:0] mask_level,
    input wire logic man_rst,
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire logic [2:0] acc_idx,
    input wire logic req,
    input wire logic [3:0] level,
    input wire logic acc_ready,
    input wire logic [15:0] acc_rdata
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);
    // One-cycle answer pulse
    sequence s_answer;
        ##1 acc_ready ##1 !acc_ready;
    endsequence
    // Request low for three cycles, starting two cycles after flags and levels are wiped
    sequence s_quiet;
        ##2 !req [*3];
    endsequence
    a_acc_answer: assert property (acc_valid |-> s_answer)
        else $error("device access not answered next cycle");
    a_ready_cause: assert property (acc_ready |-> $past(acc_valid))
        else $error("answer without access");
    a_write_quiet: assert property (acc_ready && $past(acc_valid && acc_write)
        |-> acc_rdata == 16'h0000)
        else $error("write answer carries data");
    a_upper_zero: assert property (acc_ready
        && $past(acc_valid && !acc_write && acc_idx == eip_pkg::IDX_FLAGS)
        |-> acc_rdata[15:8] == 8'h00)
        else $error("upper flag bits not zero");
    a_above_mask: assert property (req |-> level > $past(mask_level))
        else $error("request not above mask level");
    a_held_masked: assert property ($past(mask_level) == 4'hF |-> !req)
        else $error("request under full mask");
    a_level_live: assert property (req |-> level != 4'h0)
        else $error("request at level zero");
    a_mrst_clears: assert property (man_rst |-> s_quiet)
        else $error("request survives manual reset");
endmodule // eip_checker

// file: eip_core.sv
// Processor core end: takes interrupts and drives the controller link.
// Assumes a single AHB-Lite master; this module is its only slave.
module eip_core #(
    parameter int DEC_PERIOD = eip_pkg::DEC_PERIOD_CYC
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [7:0] vector_number_lines,
    eip_if.core lnk
);
    eip_pkg::eip_core_state_t state_q;
    logic hreadyout_q;
    logic [31:0] hrdata_q;
    logic wr_q;
    logic [7:0] wa_q;
    logic extvec_q;
    logic [3:0] mask_q;
    logic [31:0] pc_q;
    logic [31:0] saved_sr_q;
    logic [7:0] vec_q;
    logic [2:0] sp_q;
    logic [31:0] stk_q [eip_pkg::STK_DEPTH];
    logic [31:0] vtab_q [eip_pkg::VTAB_DEPTH];
    logic [7:0] dec_cnt_q;
    logic ack_q;
    logic [2:0] ack_src_q;
    logic man_rst_q;
    logic acc_valid_q;
    logic acc_write_q;
    logic [2:0] acc_idx_q;
    logic [15:0] acc_wdata_q;
    logic acc_busy_q;
    logic [15:0] acc_data_q;
    logic [31:0] rd_val;

    wire sel = hsel & htrans[1] & hready;
    wire [7:0] ra = haddr[7:0];
    wire w_ctrl = wr_q && wa_q == eip_pkg::OFS_CTRL;
    wire w_mask = wr_q && wa_q == eip_pkg::OFS_MASK;
    wire w_acc = wr_q && wa_q == eip_pkg::OFS_ACC && !acc_busy_q;
    wire w_pc = wr_q && wa_q == eip_pkg::OFS_PC;
    wire w_vtab = wr_q && wa_q[7:6] == eip_pkg::OFS_VTAB_HI;
    wire w_ret = wr_q && wa_q == eip_pkg::OFS_RETURN && state_q == eip_pkg::ST_RUN && sp_q >= 3'h2;
    wire dec_tick = dec_cnt_q == 8'(DEC_PERIOD - 1);
    wire take = state_q == eip_pkg::ST_RUN && dec_tick && lnk.req && !w_ret &&
                32'(sp_q) <= eip_pkg::STK_DEPTH - 2;
    wire [31:0] sr_now = {28'h0000000, mask_q};

    assign rd_val = (ra == eip_pkg::OFS_CTRL) ? {31'h00000000, extvec_q} :
                    (ra == eip_pkg::OFS_MASK) ? {28'h0000000, mask_q} :
                    (ra == eip_pkg::OFS_ACC_DATA) ? {acc_busy_q, 15'h0000, acc_data_q} :
                    (ra == eip_pkg::OFS_PC) ? pc_q :
                    (ra == eip_pkg::OFS_STATUS) ? {state_q != eip_pkg::ST_RUN, 16'h0000,
                                                   sp_q, vec_q, mask_q} :
                    (ra[7:4] == eip_pkg::OFS_STACK_HI) ? stk_q[ra[3:2]] :
                    (ra[7:6] == eip_pkg::OFS_VTAB_HI) ? vtab_q[ra[5:2]] : 32'h00000000;

    // AHB-Lite slave: zero wait, OKAY only
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            hreadyout_q <= 1'b1;
            hrdata_q <= 32'h00000000;
            wr_q <= 1'b0;
            wa_q <= 8'h00;
        end else begin
            hreadyout_q <= 1'b1;
            hrdata_q <= (sel && !hwrite) ? rd_val : 32'h00000000;
            wr_q <= sel & hwrite;
            wa_q <= ra;
        end
    end

    // Decode rate enable
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            dec_cnt_q <= 8'h00;
        end else begin
            dec_cnt_q <= dec_tick ? 8'h00 : 8'(dec_cnt_q + 8'h01);
        end
    end

    // Link access requests, manual reset pulse and external vector select
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            extvec_q <= 1'b0;
            man_rst_q <= 1'b0;
            acc_valid_q <= 1'b0;
            acc_write_q <= 1'b0;
            acc_idx_q <= 3'h0;
            acc_wdata_q <= 16'h0000;
            acc_busy_q <= 1'b0;
            acc_data_q <= 16'h0000;
        end else begin
            man_rst_q <= w_ctrl & hwdata[eip_pkg::CTRL_MRST_BIT];
            acc_valid_q <= w_acc;
            if (w_ctrl) begin
                extvec_q <= hwdata[eip_pkg::CTRL_EXTVEC_BIT];
            end
            if (w_acc) begin
                acc_write_q <= hwdata[eip_pkg::ACC_WR_BIT];
                acc_idx_q <= hwdata[eip_pkg::ACC_IDX_LSB +: 3];
                acc_wdata_q <= hwdata[15:0];
                acc_busy_q <= 1'b1;
            end else if (lnk.acc_ready) begin
                acc_data_q <= lnk.acc_rdata;
                acc_busy_q <= 1'b0;
            end
        end
    end

    // Exception entry and return
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= eip_pkg::ST_RUN;
            mask_q <= eip_pkg::MASK_RST;
            pc_q <= 32'h00000000;
            saved_sr_q <= 32'h00000000;
            vec_q <= 8'h00;
            sp_q <= 3'h0;
            ack_q <= 1'b0;
            ack_src_q <= 3'h0;
            for (int i = 0; i < eip_pkg::STK_DEPTH; i++) begin
                stk_q[i] <= 32'h00000000;
            end
            for (int i = 0; i < eip_pkg::VTAB_DEPTH; i++) begin
                vtab_q[i] <= 32'h00000000;
            end
        end else begin
            ack_q <= take;
            if (w_vtab) begin
                vtab_q[wa_q[5:2]] <= hwdata;
            end
            unique case (state_q)
                eip_pkg::ST_RUN: begin
                    if (w_ret) begin
                        pc_q <= stk_q[sp_q[1:0] - 2'h1];
                        mask_q <= stk_q[sp_q[1:0] - 2'h2][3:0];
                        sp_q <= 3'(sp_q - 3'h2);
                    end else if (take) begin
                        ack_src_q <= lnk.src;
                        saved_sr_q <= sr_now;
                        mask_q <= lnk.level;
                        vec_q <= extvec_q ? vector_number_lines : lnk.vec;
                        state_q <= eip_pkg::ST_PUSH_SR;
                    end else begin
                        if (w_mask) begin
                            mask_q <= hwdata[3:0];
                        end
                        if (w_pc) begin
                            pc_q <= hwdata;
                        end
                    end
                end
                eip_pkg::ST_PUSH_SR: begin
                    stk_q[sp_q[1:0]] <= saved_sr_q;
                    sp_q <= 3'(sp_q + 3'h1);
                    state_q <= eip_pkg::ST_PUSH_PC;
                end
                eip_pkg::ST_PUSH_PC: begin
                    stk_q[sp_q[1:0]] <= pc_q;
                    sp_q <= 3'(sp_q + 3'h1);
                    state_q <= eip_pkg::ST_VEC;
                end
                eip_pkg::ST_VEC: begin
                    pc_q <= vtab_q[vec_q[3:0]];
                    state_q <= eip_pkg::ST_RUN;
                end
            endcase
        end
    end

    assign hreadyout = hreadyout_q;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign lnk.mask_level = mask_q;
    assign lnk.ack = ack_q;
    assign lnk.ack_src = ack_src_q;
    assign lnk.man_rst = man_rst_q;
    assign lnk.acc_valid = acc_valid_q;
    assign lnk.acc_write = acc_write_q;
    assign lnk.acc_idx = acc_idx_q;
    assign lnk.acc_wdata = acc_wdata_q;
endmodule // eip_core

// file: eip_dev.sv
// Request controller end: flags, sense modes, priorities, arbitration.
// Assumes request pins synchronous to ref_clk and the core end on the link.
module eip_dev (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [7:0] ext_req_n,
    eip_if.dev lnk
);
    // Priority of source i from the two priority registers
    function automatic logic [3:0] src_level(input logic [31:0] prio, input int i);
        int base;
        base = (i < 4) ? (15 - 4 * i) : (31 - 4 * (i - 4));
        return prio[base -: 4];
    endfunction

    // Two-bit sense code of source i
    function automatic logic [1:0] sense_of(input logic [15:0] sense, input int i);
        return sense[2*i +: 2];
    endfunction

    logic [7:0] pin_q;
    logic [7:0] flags_q;
    logic [7:0] flags_d;
    logic [7:0] armed_q;
    logic [7:0] armed_d;
    logic [15:0] sense_q;
    logic [15:0] prio_lo_q;
    logic [15:0] prio_hi_q;
    logic req_q;
    logic [3:0] level_q;
    logic [2:0] src_q;
    logic [7:0] vec_q;
    logic acc_ready_q;
    logic [15:0] acc_rdata_q;
    logic [31:0] prio_all;
    logic [31:0] levels;
    logic [7:0] edge_mode;
    logic [7:0] level_mode;
    logic [7:0] edge_hit;
    logic [7:0] clr_wr;
    logic [7:0] clr_ack;
    logic win_valid;
    logic [2:0] win_src;
    logic [3:0] win_level;
    logic [15:0] rd_val;

    // Access decode
    wire acc_rd = lnk.acc_valid & ~lnk.acc_write;
    wire acc_wr = lnk.acc_valid & lnk.acc_write;
    wire rd_flags = acc_rd && lnk.acc_idx == eip_pkg::IDX_FLAGS;
    wire wr_flags = acc_wr && lnk.acc_idx == eip_pkg::IDX_FLAGS;
    wire wr_sense = acc_wr && lnk.acc_idx == eip_pkg::IDX_SENSE;
    wire wr_prio_lo = acc_wr && lnk.acc_idx == eip_pkg::IDX_PRIO_LO;
    wire wr_prio_hi = acc_wr && lnk.acc_idx == eip_pkg::IDX_PRIO_HI;
    wire accept = win_valid && (win_level > lnk.mask_level);

    // Pin transitions against the previous sample
    wire [7:0] pin_fell = pin_q & ~ext_req_n;
    wire [7:0] pin_rose = ~pin_q & ext_req_n;

    assign prio_all = {prio_hi_q, prio_lo_q};

    // Per-source sense decode and edge detection
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            level_mode[i] = sense_of(sense_q, i) == eip_pkg::SENSE_LOW;
            edge_mode[i] = sense_of(sense_q, i) == eip_pkg::SENSE_FALL ||
                           sense_of(sense_q, i) == eip_pkg::SENSE_RISE;
            edge_hit[i] = (sense_of(sense_q, i) == eip_pkg::SENSE_FALL && pin_fell[i]) ||
                          (sense_of(sense_q, i) == eip_pkg::SENSE_RISE && pin_rose[i]);
            levels[i*4 +: 4] = src_level(prio_all, i);
        end
    end

    // Clears: zero written to an armed flag, or acceptance by the core
    assign clr_wr = {8{wr_flags}} & ~lnk.acc_wdata[7:0] & armed_q;
    assign clr_ack = {8{lnk.ack}} & 8'(8'h01 << lnk.ack_src);

    // Next flag value per mode; reserved code holds the flag at zero
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (level_mode[i]) begin
                flags_d[i] = ~ext_req_n[i];
            end else if (edge_mode[i]) begin
                // Set wins over either clear
                flags_d[i] = edge_hit[i] | (flags_q[i] & ~clr_wr[i] & ~clr_ack[i]);
            end else begin
                flags_d[i] = 1'b0;
            end
        end
    end

    // A flag read while one arms its clear; any clear disarms it
    assign armed_d = (armed_q | ({8{rd_flags}} & flags_q)) & ~clr_wr & ~clr_ack;

    // Read data; flag register upper byte is zero
    assign rd_val = (lnk.acc_idx == eip_pkg::IDX_FLAGS) ? {8'h00, flags_q} :
                    (lnk.acc_idx == eip_pkg::IDX_SENSE) ? sense_q :
                    (lnk.acc_idx == eip_pkg::IDX_PRIO_LO) ? prio_lo_q :
                    (lnk.acc_idx == eip_pkg::IDX_PRIO_HI) ? prio_hi_q : 16'h0000;

    eip_pick #(
        .N(8)
    ) u_pick (
        .pending(flags_q),
        .levels(levels),
        .win_valid(win_valid),
        .win_src(win_src),
        .win_level(win_level)
    );

    // Pin history for edge detection
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_q <= eip_pkg::PIN_IDLE;
        end else begin
            pin_q <= ext_req_n;
        end
    end

    // Flags and clear arming; no standby input exists, so only reset and manual reset wipe them
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            flags_q <= eip_pkg::FLAGS_RST;
            armed_q <= 8'h00;
        end else if (lnk.man_rst) begin
            flags_q <= eip_pkg::FLAGS_RST;
            armed_q <= 8'h00;
        end else begin
            flags_q <= flags_d;
            armed_q <= armed_d;
        end
    end

    // Sense and priority registers
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sense_q <= eip_pkg::SENSE_RST;
            prio_lo_q <= eip_pkg::PRIO_RST;
            prio_hi_q <= eip_pkg::PRIO_RST;
        end else if (lnk.man_rst) begin
            sense_q <= eip_pkg::SENSE_RST;
            prio_lo_q <= eip_pkg::PRIO_RST;
            prio_hi_q <= eip_pkg::PRIO_RST;
        end else begin
            if (wr_sense) begin
                sense_q <= lnk.acc_wdata;
            end
            if (wr_prio_lo) begin
                prio_lo_q <= lnk.acc_wdata;
            end
            if (wr_prio_hi) begin
                prio_hi_q <= lnk.acc_wdata;
            end
        end
    end

    // Access answer one cycle after the request
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_ready_q <= 1'b0;
            acc_rdata_q <= 16'h0000;
        end else begin
            acc_ready_q <= lnk.acc_valid;
            acc_rdata_q <= acc_rd ? rd_val : 16'h0000;
        end
    end

    // Request toward the core; dropped the cycle after the core acknowledges
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            req_q <= 1'b0;
            level_q <= 4'h0;
            src_q <= 3'h0;
            vec_q <= 8'h00;
        end else begin
            req_q <= accept & ~lnk.ack & ~lnk.man_rst;
            level_q <= win_level;
            src_q <= win_src;
            vec_q <= 8'(eip_pkg::VEC_INT_BASE + {5'h00, win_src});
        end
    end

    assign lnk.req = req_q;
    assign lnk.level = level_q;
    assign lnk.src = src_q;
    assign lnk.vec = vec_q;
    assign lnk.acc_ready = acc_ready_q;
    assign lnk.acc_rdata = acc_rdata_q;
endmodule // eip_dev

// file: eip_if.sv
// Link between the request controller and the processor core.
// Both ends run on the same clock, supplied separately.
interface eip_if;
    logic [3:0] mask_level;
    logic ack;
    logic [2:0] ack_src;
    logic man_rst;
    logic acc_valid;
    logic acc_write;
    logic [2:0] acc_idx;
    logic [15:0] acc_wdata;
    logic req;
    logic [3:0] level;
    logic [2:0] src;
    logic [7:0] vec;
    logic acc_ready;
    logic [15:0] acc_rdata;

    modport dev (
        input mask_level, ack, ack_src, man_rst, acc_valid, acc_write, acc_idx, acc_wdata,
        output req, level, src, vec, acc_ready, acc_rdata
    );
    modport core (
        output mask_level, ack, ack_src, man_rst, acc_valid, acc_write, acc_idx, acc_wdata,
        input req, level, src, vec, acc_ready, acc_rdata
    );
endinterface

// file: eip_pick.sv
// Priority picker: highest level wins, lowest index wins ties.
// Purely combinational; inputs come from registers of the caller.
module eip_pick #(
    parameter int N = 8
) (
    input wire logic [N-1:0] pending,
    input wire logic [N*4-1:0] levels,
    output logic win_valid,
    output logic [2:0] win_src,
    output logic [3:0] win_level
);
    always_comb begin
        win_valid = 1'b0;
        win_src = 3'h0;
        win_level = 4'h0;
        for (int i = N - 1; i >= 0; i--) begin
            // Level zero never wins; equal level goes to the lower index
            if (pending[i] && levels[i*4 +: 4] != 4'h0 && levels[i*4 +: 4] >= win_level) begin
                win_valid = 1'b1;
                win_src = 3'(i);
                win_level = levels[i*4 +: 4];
            end
        end
    end
endmodule // eip_pick

// file: eip_pkg.sv
// Constants shared by both ends of the external request controller.
// Assumes one 200 MHz clock for both ends.
package eip_pkg;
    // Sources and widths
    localparam int NSRC = 8;
    localparam int LVL_W = 4;
    localparam int SRC_W = 3;
    // Device register indices on the link
    localparam logic [2:0] IDX_FLAGS = 3'h0;
    localparam logic [2:0] IDX_SENSE = 3'h1;
    localparam logic [2:0] IDX_PRIO_LO = 3'h2;
    localparam logic [2:0] IDX_PRIO_HI = 3'h3;
    // Device reset values
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [15:0] SENSE_RST = 16'h0000;
    localparam logic [15:0] PRIO_RST = 16'h0000;
    localparam logic [7:0] PIN_IDLE = 8'hFF;
    // Sense codes
    localparam logic [1:0] SENSE_LOW = 2'h0;
    localparam logic [1:0] SENSE_FALL = 2'h1;
    localparam logic [1:0] SENSE_RISE = 2'h2;
    localparam logic [1:0] SENSE_RSVD = 2'h3;
    // Internal vector base, value arbitrary
    localparam logic [7:0] VEC_INT_BASE = 8'h40;
    // Core register byte offsets on AHB-Lite
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MASK = 8'h04;
    localparam logic [7:0] OFS_ACC = 8'h08;
    localparam logic [7:0] OFS_ACC_DATA = 8'h0C;
    localparam logic [7:0] OFS_PC = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_RETURN = 8'h18;
    localparam logic [3:0] OFS_STACK_HI = 4'h2;
    localparam logic [1:0] OFS_VTAB_HI = 2'h1;
    // Core register fields
    localparam int CTRL_EXTVEC_BIT = 0;
    localparam int CTRL_MRST_BIT = 1;
    localparam int ACC_IDX_LSB = 16;
    localparam int ACC_WR_BIT = 19;
    localparam int BUSY_BIT = 31;
    localparam int STAT_VEC_LSB = 4;
    localparam int STAT_SP_LSB = 12;
    // Core reset values and sizes
    localparam logic [3:0] MASK_RST = 4'hF;
    localparam int STK_DEPTH = 4;
    localparam int VTAB_DEPTH = 16;
    // Instruction decode rate
    localparam int CLK_PERIOD_NS = 5;
    localparam int DEC_PERIOD_NS = 20;
    localparam int DEC_PERIOD_CYC = (DEC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Core states
    typedef enum logic [3:0] {
        ST_RUN = 4'b0001,
        ST_PUSH_SR = 4'b0010,
        ST_PUSH_PC = 4'b0100,
        ST_VEC = 4'b1000
    } eip_core_state_t;
endpackage

// file: tb_top.sv
// Bench joining both ends of the external request controller.
// Assumes the package, link interface, both ends and the checker.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [1:0] sense; logic lo; logic hi;} eip_row_t;
    logic ref_clk = 1'h0;
    logic arst_n = 1'h0;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [31:0] hwdata = 32'h0;
    logic [7:0] ext_req_n = 8'hFF;
    logic [7:0] vec_lines = 8'h00;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [31:0] smp_rd;
    logic smp_ry;
    logic [31:0] junk;
    logic [15:0] r16;
    int err_total = 0;
    int checked = 0;
    int cyc = 0;
    eip_row_t rows [4] = '{'{eip_pkg::SENSE_LOW, 1'h1, 1'h0},
        '{eip_pkg::SENSE_FALL, 1'h1, 1'h1}, '{eip_pkg::SENSE_RISE, 1'h0, 1'h1},
        '{eip_pkg::SENSE_RSVD, 1'h0, 1'h0}};
    eip_if lnk ();
    always #2.5 ref_clk = ~ref_clk;
    eip_dev u_eip_dev (.ref_clk(ref_clk), .arst_n(arst_n), .ext_req_n(ext_req_n), .lnk(lnk));
    eip_core #(.DEC_PERIOD(4)) u_eip_core (.ref_clk(ref_clk), .arst_n(arst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .vector_number_lines(vec_lines), .lnk(lnk));
    eip_checker u_eip_checker (.ref_clk(ref_clk), .arst_n(arst_n),
        .mask_level(lnk.mask_level), .man_rst(lnk.man_rst), .acc_valid(lnk.acc_valid),
        .acc_write(lnk.acc_write), .acc_idx(lnk.acc_idx), .req(lnk.req), .level(lnk.level),
        .acc_ready(lnk.acc_ready), .acc_rdata(lnk.acc_rdata));
    // Bus values as they stood at each edge
    always @(posedge ref_clk) begin
        smp_rd <= hrdata;
        smp_ry <= hreadyout;
    end
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            end_of_test();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rdy();
        do begin
            @(posedge ref_clk);
            #1;
        end while (smp_ry !== 1'h1);
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        hsel <= 1'h1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        rdy();
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        r = smp_rd;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'h1, a, d, junk);
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        ahb(1'h0, a, 32'h0, v);
        chk(what, exp, v);
    endtask
    // Device access through the core, polling until not busy
    task automatic dev(input logic w, input logic [2:0] idx, input logic [15:0] d);
        logic [31:0] v;
        int n;
        wr(eip_pkg::OFS_ACC, {12'h0, w, idx, d});
        n = 0;
        do begin
            ahb(1'h0, eip_pkg::OFS_ACC_DATA, 32'h0, v);
            n++;
        end while (v[eip_pkg::BUSY_BIT] !== 1'h0 && n < 20);
        chk("acc done", 32'h0, {31'h0, v[eip_pkg::BUSY_BIT]});
        r16 = v[15:0];
    endtask
    task automatic dev_chk(input string what, input logic [2:0] idx, input logic [15:0] exp);
        dev(1'h0, idx, 16'h0);
        chk(what, {16'h0, exp}, {16'h0, r16});
    endtask
    task automatic pins(input logic [7:0] v);
        ext_req_n <= v;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask
    task automatic idle();
        repeat (16) @(posedge ref_clk);
        #1;
    endtask
    initial begin
        repeat (4) @(posedge ref_clk);
        arst_n <= 1'h1;
        @(posedge ref_clk);
        #1;
        rd_chk("mask reset", eip_pkg::OFS_MASK, 32'hF);
        chk("okay resp", 32'h0, {31'h0, hresp});
        wr(8'h1C, 32'hFFFFFFFF);
        rd_chk("unmapped", 8'h1C, 32'h0);
        dev_chk("flags reset", eip_pkg::IDX_FLAGS, 16'h0);
        dev_chk("prio reset", eip_pkg::IDX_PRIO_LO, 16'h0);
        // Input 0 under each sense code
        foreach (rows[i]) begin
            dev(1'h1, eip_pkg::IDX_SENSE, {14'h0, rows[i].sense});
            pins(8'hFE);
            dev_chk("flag low", eip_pkg::IDX_FLAGS, {15'h0, rows[i].lo});
            pins(8'hFF);
            dev_chk("flag high", eip_pkg::IDX_FLAGS, {15'h0, rows[i].hi});
            dev(1'h1, eip_pkg::IDX_FLAGS, 16'h0);
            dev_chk("flag clear", eip_pkg::IDX_FLAGS, 16'h0);
        end
        // Clearing needs a prior read; ones never set
        dev(1'h1, eip_pkg::IDX_SENSE, 16'h5555);
        pins(8'hFD);
        pins(8'hFF);
        dev(1'h1, eip_pkg::IDX_FLAGS, 16'h0);
        dev_chk("unread clear", eip_pkg::IDX_FLAGS, 16'h0002);
        dev(1'h1, eip_pkg::IDX_FLAGS, 16'hFFFF);
        dev_chk("write one", eip_pkg::IDX_FLAGS, 16'h0002);
        dev(1'h1, eip_pkg::IDX_FLAGS, 16'h0);
        dev_chk("read clear", eip_pkg::IDX_FLAGS, 16'h0);
        // Arbitration and entry: inputs 2 and 5 at level 5, input 6 at 9
        for (int k = 0; k < 16; k++) begin
            wr(8'h40 + 8'(4 * k), 32'h1000 + 32'(k));
        end
        dev(1'h1, eip_pkg::IDX_PRIO_LO, 16'h0050);
        dev(1'h1, eip_pkg::IDX_PRIO_HI, 16'h0590);
        pins(8'h9B);
        pins(8'hFF);
        wr(eip_pkg::OFS_MASK, 32'h9);
        idle();
        dev_chk("held at mask", eip_pkg::IDX_FLAGS, 16'h0064);
        rd_chk("no entry", eip_pkg::OFS_STATUS, 32'h00000009);
        wr(eip_pkg::OFS_MASK, 32'h8);
        idle();
        rd_chk("first pc", eip_pkg::OFS_PC, 32'h1006);
        rd_chk("first status", eip_pkg::OFS_STATUS, 32'h00002469);
        dev_chk("after first", eip_pkg::IDX_FLAGS, 16'h0024);
        wr(eip_pkg::OFS_MASK, 32'h4);
        idle();
        rd_chk("tie pc", eip_pkg::OFS_PC, 32'h1002);
        dev_chk("after tie", eip_pkg::IDX_FLAGS, 16'h0020);
        rd_chk("pushed status", 8'h28, 32'h4);
        rd_chk("pushed pc", 8'h2C, 32'h1006);
        vec_lines <= 8'h4B;
        wr(eip_pkg::OFS_CTRL, 32'h1);
        wr(eip_pkg::OFS_RETURN, 32'h0);
        idle();
        rd_chk("ext pc", eip_pkg::OFS_PC, 32'h100B);
        rd_chk("ext status", eip_pkg::OFS_STATUS, 32'h000044B5);
        dev_chk("all taken", eip_pkg::IDX_FLAGS, 16'h0);
        // Manual reset wipes flags and sense codes
        pins(8'hF7);
        pins(8'hFF);
        dev_chk("edge set", eip_pkg::IDX_FLAGS, 16'h0008);
        wr(eip_pkg::OFS_CTRL, 32'h2);
        dev_chk("mrst flags", eip_pkg::IDX_FLAGS, 16'h0);
        dev_chk("mrst sense", eip_pkg::IDX_SENSE, 16'h0);
        // Edge in the cycle of an armed clear, then a mid-run reset
        dev(1'h1, eip_pkg::IDX_SENSE, 16'h0001);
        pins(8'hFE);
        pins(8'hFF);
        dev_chk("armed flag", eip_pkg::IDX_FLAGS, 16'h0001);
        wr(eip_pkg::OFS_ACC, {12'h0, 1'h1, eip_pkg::IDX_FLAGS, 16'h0});
        pins(8'hFE);
        dev_chk("set beats clear", eip_pkg::IDX_FLAGS, 16'h0001);
        pins(8'hFF);
        arst_n <= 1'h0;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'h1;
        @(posedge ref_clk);
        #1;
        dev_chk("arst flags", eip_pkg::IDX_FLAGS, 16'h0);
        dev_chk("arst sense", eip_pkg::IDX_SENSE, 16'h0);
        rd_chk("arst mask", eip_pkg::OFS_MASK, 32'hF);
        end_of_test();
    end
endmodule // tb_top
